// >>> logic/tmu_pkg.sv
package tmu_pkg;

  // timer number space and word widths
  localparam int unsigned NUM_TIMERS   = 4096;
  localparam int unsigned NUM_W        = 12;
  localparam int unsigned SV_W         = 16;
  localparam int unsigned STAMP_W      = 17;
  localparam int unsigned ADDR_W       = 8;
  localparam int unsigned DATA_W       = 32;

  // timing: clock period and tick period, both in ns
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned TICK_NS       = 100_000;
  localparam int unsigned TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TICK_CNT_W    = $clog2(TICK_CYCLES);

  // set value limits per variant
  localparam logic [SV_W-1:0] SV_MAX_BCD = 16'h9999;
  localparam logic [SV_W-1:0] SV_MAX_BIN = 16'hFFFF;

  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] REG_CTRL      = 8'h00;
  localparam logic [ADDR_W-1:0] REG_FLAG_SEL  = 8'h04;
  localparam logic [ADDR_W-1:0] REG_FLAG_DATA = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STATUS    = 8'h0C;

  // field positions
  localparam int unsigned CTRL_RETAIN_BIT  = 0;
  localparam int unsigned CTRL_PROTECT_BIT = 1;
  localparam int unsigned STAT_ERROR_BIT   = 0;
  localparam int unsigned STAT_FLAG_BIT    = 1;
  localparam int unsigned STAT_TICK_BIT    = 2;

  // reset values
  localparam logic [1:0]        CTRL_RESET     = 2'h0;
  localparam logic [NUM_W-1:0]  FLAG_SEL_RESET = 12'h000;
  localparam logic [DATA_W-1:0] RDATA_RESET    = 32'h0000_0000;

  // every nibble of the word in 0..9
  function automatic logic is_bcd(input logic [SV_W-1:0] w);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < SV_W / 4; i++) begin
      if (w[i*4 +: 4] > 4'h9) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction : is_bcd

  // bcd word to tick count
  function automatic logic [SV_W-1:0] bcd_to_ticks(input logic [SV_W-1:0] w);
    logic [SV_W-1:0] v;
    v = 16'h0000;
    for (int i = SV_W / 4 - 1; i >= 0; i--) begin
      v = SV_W'(v * 16'h000A + SV_W'(w[i*4 +: 4]));
    end
    return v;
  endfunction : bcd_to_ticks

endpackage : tmu_pkg

// >>> logic/tmu_tick_base.sv
module tmu_tick_base (
  // clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        srst,
  // free-running time base
  output logic                             tick,
  output logic [tmu_pkg::STAMP_W-1:0]      now_stamp
);

  logic [tmu_pkg::TICK_CNT_W-1:0] div_cnt;
  logic [tmu_pkg::TICK_CNT_W-1:0] next_div_cnt;
  logic                           next_tick;
  logic [tmu_pkg::STAMP_W-1:0]    next_now_stamp;

  // one pulse per 0.1 ms, stamp counts pulses
  always_comb begin
    next_tick      = 1'b0;
    next_now_stamp = now_stamp;
    if (div_cnt == tmu_pkg::TICK_CNT_W'(tmu_pkg::TICK_CYCLES - 1)) begin
      next_div_cnt   = '0;
      next_tick      = 1'b1;
      next_now_stamp = now_stamp + tmu_pkg::STAMP_W'(1);
    end else begin
      next_div_cnt = div_cnt + tmu_pkg::TICK_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      div_cnt   <= '0;
      tick      <= 1'b0;
      now_stamp <= '0;
    end else begin
      div_cnt   <= next_div_cnt;
      tick      <= next_tick;
      now_stamp <= next_now_stamp;
    end
  end

endmodule : tmu_tick_base

// >>> logic/tmu_timer.sv
// Overview of operation
// - error flag on for non-bcd set value in bcd variant, else off
// - error flag on for bad index-register timer address; equals flag untouched
// - execution with input off resets the timer and clears its flag
// - input rising starts counting in 0.1 ms steps; flag on after set value
// - flag holds after timeout; restart needs input off then on
// - present count stays internal; only the completion flag is readable
// - range 0..0.9999 s bcd, 0..6.5535 s binary
// - timing error between -0.1 ms and 0, never late
// - each non-jumped, error-free execution sets flag if set value reached, clears it otherwise
// - flag only changes on execution, may lag timeout by one scan
// - mode change clears flags unless retain bit is on
// - power restore clears flags unless retain bit on and protected
// - reset-timer/counter op clears the targeted timer's flag
// - interlocked execution restores count to set value and clears flag
// - jumped section leaves the flag unchanged; counting continues
// - forced set turns flag on, forced reset turns it off
// - same number used twice works only if never active together
//
// The strobed register port and the register addresses were decided locally.
module tmu_timer (
  // clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        srst,
  // register port
  input  wire logic [tmu_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [tmu_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic [tmu_pkg::DATA_W-1:0]       reg_rdata,
  // instruction execution from the scan
  input  wire logic                        exec_valid,
  input  wire logic [tmu_pkg::NUM_W-1:0]   exec_timer_num,
  input  wire logic [tmu_pkg::SV_W-1:0]    exec_set_value,
  input  wire logic                        exec_binary,
  input  wire logic                        exec_input,
  input  wire logic                        exec_index_bad,
  input  wire logic                        exec_interlocked,
  input  wire logic                        exec_jumped,
  output logic                             exec_done,
  output logic                             completion_flag,
  output logic                             error_flag,
  // reset-timer/counter op over a number range
  input  wire logic                        reset_timer_counter_op,
  input  wire logic [tmu_pkg::NUM_W-1:0]   rst_op_first,
  input  wire logic [tmu_pkg::NUM_W-1:0]   rst_op_last,
  // forcing from the programming tool
  input  wire logic                        force_valid,
  input  wire logic                        force_on,
  input  wire logic [tmu_pkg::NUM_W-1:0]   force_num,
  // system events
  input  wire logic                        mode_change,
  input  wire logic                        power_restore
);

  localparam int unsigned N = tmu_pkg::NUM_TIMERS;

  logic                             tick;
  logic [tmu_pkg::STAMP_W-1:0]      now_stamp;

  // per-timer state: completion flag, armed, start stamp
  logic                             done_arr     [N];
  logic                             run_arr      [N];
  logic [tmu_pkg::STAMP_W-1:0]      stamp_arr    [N];
  logic                             next_done_arr[N];
  logic                             next_run_arr [N];
  logic [tmu_pkg::STAMP_W-1:0]      next_stamp_arr[N];

  // execution result
  logic                             next_exec_done;
  logic                             next_completion_flag;
  logic                             next_error_flag;

  // register state
  logic                             io_memory_retain_bit;
  logic                             retain_protect;
  logic [tmu_pkg::NUM_W-1:0]        flag_sel;
  logic                             tick_seen;
  logic                             next_retain_bit;
  logic                             next_retain_protect;
  logic [tmu_pkg::NUM_W-1:0]        next_flag_sel;
  logic                             next_tick_seen;
  logic [tmu_pkg::DATA_W-1:0]       next_reg_rdata;

  // decode helpers
  logic                             sv_bcd_ok;
  logic [tmu_pkg::SV_W-1:0]         sv_ticks;
  logic [tmu_pkg::STAMP_W-1:0]      elapsed;
  logic                             reached;

  // table action of this cycle
  typedef enum logic [2:0] {
    ACT_IDLE,
    ACT_CLEAR_ALL,
    ACT_RANGE_RESET,
    ACT_FORCE,
    ACT_EXEC
  } tmu_act_e;
  tmu_act_e                         act;
  logic                             exec_err;

  tmu_tick_base u_tick_base (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .tick      (tick),
    .now_stamp (now_stamp)
  );

  function automatic logic in_range(
    input logic [tmu_pkg::NUM_W-1:0] idx,
    input logic [tmu_pkg::NUM_W-1:0] lo,
    input logic [tmu_pkg::NUM_W-1:0] hi
  );
    return (idx >= lo) && (idx <= hi);
  endfunction : in_range

  // time since start, modulo the stamp width
  always_comb begin
    sv_bcd_ok = tmu_pkg::is_bcd(exec_set_value);
    sv_ticks  = exec_binary ? exec_set_value
                            : tmu_pkg::bcd_to_ticks(exec_set_value);
    elapsed   = now_stamp - stamp_arr[exec_timer_num];
    // start lands anywhere within a tick, so timeout is up to one tick early
    reached   = elapsed >= {1'b0, sv_ticks};
  end

  // one table action per cycle, highest priority first
  always_comb begin
    act = ACT_IDLE;
    if (power_restore && !(io_memory_retain_bit && retain_protect)) begin
      act = ACT_CLEAR_ALL;
    end else if (mode_change && !io_memory_retain_bit) begin
      act = ACT_CLEAR_ALL;
    end else if (reset_timer_counter_op) begin
      act = ACT_RANGE_RESET;
    end else if (force_valid) begin
      act = ACT_FORCE;
    end else if (exec_valid) begin
      // an execution that loses to any event above gets no answer
      act = ACT_EXEC;
    end
    exec_err = exec_index_bad || (!exec_binary && !sv_bcd_ok);
  end

  // timer table
  always_comb begin
    for (int i = 0; i < N; i++) begin
      next_done_arr[i]  = done_arr[i];
      next_run_arr[i]   = run_arr[i];
      next_stamp_arr[i] = stamp_arr[i];
    end
    next_exec_done       = 1'b0;
    next_completion_flag = completion_flag;
    next_error_flag      = error_flag;

    unique case (act)
      ACT_CLEAR_ALL: begin
        // stamps need no clearing: a cleared timer rearms from a fresh stamp
        for (int i = 0; i < N; i++) begin
          next_done_arr[i] = 1'b0;
          next_run_arr[i]  = 1'b0;
        end
      end
      ACT_RANGE_RESET: begin
        for (int i = 0; i < N; i++) begin
          if (in_range(tmu_pkg::NUM_W'(i), rst_op_first, rst_op_last)) begin
            next_done_arr[i] = 1'b0;
            next_run_arr[i]  = 1'b0;
          end
        end
      end
      ACT_FORCE: begin
        next_done_arr[force_num] = force_on;
        next_run_arr[force_num]  = force_on;
        if (force_on) begin
          // forced set looks like a timer already run out
          next_stamp_arr[force_num] = now_stamp - tmu_pkg::STAMP_W'(tmu_pkg::SV_MAX_BIN);
        end
      end
      ACT_EXEC: begin
        next_exec_done  = 1'b1;
        // an erroring execution leaves the timer table alone
        next_error_flag = exec_err;
        if (!exec_err) begin
          if (exec_jumped) begin
            // not executed: flag kept, stamp keeps aging
            next_done_arr[exec_timer_num] = done_arr[exec_timer_num];
          end else if (exec_interlocked || !exec_input) begin
            next_done_arr[exec_timer_num] = 1'b0;
            next_run_arr[exec_timer_num]  = 1'b0;
          end else if (!run_arr[exec_timer_num]) begin
            // rising input: start from the set value
            next_run_arr[exec_timer_num]   = 1'b1;
            next_stamp_arr[exec_timer_num] = now_stamp;
            next_done_arr[exec_timer_num]  = (sv_ticks == '0);
          end else begin
            next_done_arr[exec_timer_num] = done_arr[exec_timer_num]
                                          || reached;
          end
        end
        next_completion_flag = next_done_arr[exec_timer_num];
      end
      ACT_IDLE: begin
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      for (int i = 0; i < N; i++) begin
        done_arr[i]  <= 1'b0;
        run_arr[i]   <= 1'b0;
        stamp_arr[i] <= '0;
      end
      exec_done       <= 1'b0;
      completion_flag <= 1'b0;
      error_flag      <= 1'b0;
    end else begin
      for (int i = 0; i < N; i++) begin
        done_arr[i]  <= next_done_arr[i];
        run_arr[i]   <= next_run_arr[i];
        stamp_arr[i] <= next_stamp_arr[i];
      end
      exec_done       <= next_exec_done;
      completion_flag <= next_completion_flag;
      error_flag      <= next_error_flag;
    end
  end

  // control registers
  always_comb begin
    next_retain_bit     = io_memory_retain_bit;
    next_retain_protect = retain_protect;
    next_flag_sel       = flag_sel;
    if (reg_wr) begin
      unique case (reg_addr)
        tmu_pkg::REG_CTRL: begin
          next_retain_bit     = reg_wdata[tmu_pkg::CTRL_RETAIN_BIT];
          next_retain_protect = reg_wdata[tmu_pkg::CTRL_PROTECT_BIT];
        end
        tmu_pkg::REG_FLAG_SEL: begin
          next_flag_sel = reg_wdata[tmu_pkg::NUM_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      io_memory_retain_bit <= tmu_pkg::CTRL_RESET[tmu_pkg::CTRL_RETAIN_BIT];
      retain_protect       <= tmu_pkg::CTRL_RESET[tmu_pkg::CTRL_PROTECT_BIT];
      flag_sel             <= tmu_pkg::FLAG_SEL_RESET;
    end else begin
      io_memory_retain_bit <= next_retain_bit;
      retain_protect       <= next_retain_protect;
      flag_sel             <= next_flag_sel;
    end
  end

  // read path: data stands one cycle after the strobe, zero otherwise
  always_comb begin
    // a tick in the read cycle survives the clear, so none is lost
    next_tick_seen = tick_seen | tick;
    next_reg_rdata = tmu_pkg::RDATA_RESET;
    if (reg_rd) begin
      unique case (reg_addr)
        tmu_pkg::REG_CTRL: begin
          next_reg_rdata[tmu_pkg::CTRL_RETAIN_BIT]  = io_memory_retain_bit;
          next_reg_rdata[tmu_pkg::CTRL_PROTECT_BIT] = retain_protect;
        end
        tmu_pkg::REG_FLAG_SEL: begin
          next_reg_rdata[tmu_pkg::NUM_W-1:0] = flag_sel;
        end
        tmu_pkg::REG_FLAG_DATA: begin
          // only the flag is visible, never the count
          next_reg_rdata[0] = done_arr[flag_sel];
        end
        tmu_pkg::REG_STATUS: begin
          next_reg_rdata[tmu_pkg::STAT_ERROR_BIT] = error_flag;
          next_reg_rdata[tmu_pkg::STAT_FLAG_BIT]  = completion_flag;
          next_reg_rdata[tmu_pkg::STAT_TICK_BIT]  = tick_seen;
          next_tick_seen                          = tick;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tick_seen <= 1'b0;
      reg_rdata <= tmu_pkg::RDATA_RESET;
    end else begin
      tick_seen <= next_tick_seen;
      reg_rdata <= next_reg_rdata;
    end
  end

endmodule : tmu_timer

// >>> verification/tmu_timer_properties.sv
module tmu_timer_properties (
  // clock and reset
  input wire logic                       clk_sys,
  input wire logic                       srst,
  // register read
  input wire logic                       reg_rd,
  input wire logic [tmu_pkg::DATA_W-1:0] reg_rdata,
  // execution
  input wire logic                       exec_valid,
  input wire logic [tmu_pkg::SV_W-1:0]   exec_set_value,
  input wire logic                       exec_binary,
  input wire logic                       exec_input,
  input wire logic                       exec_index_bad,
  input wire logic                       exec_interlocked,
  input wire logic                       exec_jumped,
  input wire logic                       exec_done,
  input wire logic                       completion_flag,
  input wire logic                       error_flag,
  // events
  input wire logic                       reset_timer_counter_op,
  input wire logic                       force_valid,
  input wire logic                       mode_change,
  input wire logic                       power_restore
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic nib_bad;
  always_comb begin
    nib_bad = 1'b0;
    for (int i = 0; i < 4; i++) begin
      nib_bad = nib_bad | (exec_set_value[i*4 +: 4] > 4'h9);
    end
  end
  sequence s_take;
    exec_valid && !reset_timer_counter_op && !force_valid && !mode_change && !power_restore;
  endsequence
  sequence s_good;
    s_take ##0 (!exec_index_bad && (exec_binary || !nib_bad));
  endsequence
  exec_answer_a: assert property (s_take |=> exec_done)
    else $error("execution not answered");
  done_cause_a: assert property (exec_done |-> $past(exec_valid))
    else $error("done without execution");
  flag_steady_a: assert property (!exec_done && !$past(srst) |-> $stable(completion_flag))
    else $error("flag moved without execution");
  err_steady_a: assert property (!exec_done && !$past(srst) |-> $stable(error_flag))
    else $error("error flag moved without execution");
  bcd_error_a: assert property (s_take ##0 (!exec_binary && nib_bad) |=> error_flag)
    else $error("bad bcd not flagged");
  index_error_a: assert property (s_take ##0 exec_index_bad |=> error_flag)
    else $error("bad index not flagged");
  clean_error_a: assert property (s_good |=> !error_flag)
    else $error("error flag on for good execution");
  input_off_a: assert property (s_good ##0 (!exec_input && !exec_jumped) |=> !completion_flag)
    else $error("flag on with input off");
  ilock_clear_a: assert property (s_good ##0 (exec_interlocked && !exec_jumped)
    |=> !completion_flag)
    else $error("flag on when interlocked");
  zero_sv_a: assert property (s_good ##0 (exec_input && exec_set_value == 16'h0000
    && !exec_interlocked && !exec_jumped) |=> completion_flag)
    else $error("zero set value not timed out");
  read_idle_a: assert property (!reg_rd |=> reg_rdata == '0)
    else $error("read data outside read");
endmodule : tmu_timer_properties

// >>> verification/tmu_scan_model.sv
module tmu_scan_model (
  // clock and reset
  input wire logic                      clk_sys,
  input wire logic                      srst,
  // one scan request from the bench
  input wire logic                      go,
  input wire logic [tmu_pkg::NUM_W-1:0] num,
  input wire logic [tmu_pkg::SV_W-1:0]  sv,
  input wire logic [4:0]                mode,
  // instruction execution
  output logic                          exec_valid = 1'b0,
  output logic [tmu_pkg::NUM_W-1:0]     exec_timer_num = 12'h000,
  output logic [tmu_pkg::SV_W-1:0]      exec_set_value = 16'h0000,
  output logic                          exec_binary = 1'b0,
  output logic                          exec_input = 1'b0,
  output logic                          exec_index_bad = 1'b0,
  output logic                          exec_interlocked = 1'b0,
  output logic                          exec_jumped = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // one execution per request, scans far shorter than 100 ms
  // active timers use distinct numbers, no online edit
  always @(posedge clk_sys) begin
    exec_valid <= go && !srst;
    if (go) begin
      exec_timer_num <= num;
      exec_set_value <= sv;
      {exec_binary, exec_input, exec_index_bad, exec_interlocked, exec_jumped} <= mode;
    end
  end
endmodule : tmu_scan_model

// >>> verification/tenth_ms_countdown_timer_test.sv
module tenth_ms_countdown_timer_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [31:0] reg_rdata;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        go = 1'b0;
  logic [11:0] num = 12'h000;
  logic [15:0] sv = 16'h0000;
  logic [4:0]  mode = 5'h00;
  logic [3:0]  evt = 4'h0;
  logic [11:0] f_num = 12'h000;
  logic        f_on = 1'b0;
  logic        ev_valid, ev_input, ev_bin, ev_bad, ev_il, ev_jmp, exec_done, cflag, eflag;
  logic [11:0] ev_num, n;
  logic [15:0] ev_sv, s;
  logic [4:0]  m;
  logic        e;
  int          k;
  int          num_errors = 0;
  int          checks = 0;
  logic [15:0] svc [3] = '{16'h0000, 16'h9999, 16'h00A0};
  always #50 clk_sys = ~clk_sys;
  tmu_scan_model u_scan (.clk_sys(clk_sys), .srst(srst), .go(go), .num(num), .sv(sv),
    .mode(mode), .exec_valid(ev_valid), .exec_timer_num(ev_num), .exec_set_value(ev_sv),
    .exec_binary(ev_bin), .exec_input(ev_input), .exec_index_bad(ev_bad),
    .exec_interlocked(ev_il), .exec_jumped(ev_jmp));
  tmu_timer DUT (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .exec_valid(ev_valid),
    .exec_timer_num(ev_num), .exec_set_value(ev_sv), .exec_binary(ev_bin),
    .exec_input(ev_input), .exec_index_bad(ev_bad), .exec_interlocked(ev_il),
    .exec_jumped(ev_jmp), .exec_done(exec_done), .completion_flag(cflag), .error_flag(eflag),
    .reset_timer_counter_op(evt[2]), .rst_op_first(f_num), .rst_op_last(f_num),
    .force_valid(evt[3]), .force_on(f_on), .force_num(f_num), .mode_change(evt[1]),
    .power_restore(evt[0]));
  function automatic logic exp_err(input logic [15:0] w, input logic [4:0] md);
    logic r;
    r = md[2];
    for (int i = 0; i < 4; i++) begin
      if (!md[4] && w[i*4 +: 4] > 4'h9) begin
        r = 1'b1;
      end
    end
    return r;
  endfunction : exp_err
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 cmp(reg_rdata, exp);
  endtask : rd
  task automatic fd(input logic [11:0] t, input logic exp);
    wr(tmu_pkg::REG_FLAG_SEL, {20'h0_0000, t});
    rd(tmu_pkg::REG_FLAG_DATA, {31'h0, exp});
  endtask : fd
  // mode bits: binary, input, index bad, interlocked, jumped
  task automatic x(input logic [11:0] t, input logic [15:0] w, input logic [4:0] md,
                   input logic ef, input logic ee);
    @(posedge clk_sys);
    go <= 1'b1;
    num <= t;
    sv <= w;
    mode <= md;
    @(posedge clk_sys);
    go <= 1'b0;
    @(posedge clk_sys);
    #1 cmp(exec_done, 1);
    cmp(cflag, ef);
    cmp(eflag, ee);
  endtask : x
  task automatic ev(input int i, input logic on);
    @(posedge clk_sys);
    f_num <= n;
    f_on <= on;
    evt[i] <= 1'b1;
    @(posedge clk_sys);
    evt <= 4'h0;
  endtask : ev
  task automatic close_out;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (30000) @(posedge clk_sys);
    num_errors++;
    close_out();
  end
  initial begin
    k = $urandom(34);
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    rd(tmu_pkg::REG_CTRL, 0);
    wr(8'h10, 32'hFFFF_FFFF);
    rd(8'h10, 0);
    $display("registers done");
    for (int b = 0; b < 2; b++) begin
      k = 2 + $urandom_range(3);
      n = 12'($urandom_range(4095));
      s = 16'(k);
      m = b ? 5'h18 : 5'h08;
      x(n, s, m & 5'h10, 0, 0);
      x(n, s, m, 0, 0);
      repeat ((k - 1) * 1000 - 20) @(posedge clk_sys);
      x(n, s, m, 0, 0);
      repeat (1040) @(posedge clk_sys);
      x(n, s, m, 1, 0);
      x(n, s, m | 5'h01, 1, 0);
      x(n, s, m, 1, 0);
      fd(n, 1);
      x(n, s, m & 5'h10, 0, 0);
      x(n, s, m, 0, 0);
      x(n, 16'h0000, m, 1, 0);
      x(n, 16'h0000, m | 5'h02, 0, 0);
      x(n, b ? 16'hFFFF : 16'h9999, m, 0, 0);
      $display("timing variant %0d done", b);
    end
    x(12'hFFF, 16'h0001, 5'h1C, 0, 1);
    rd(tmu_pkg::REG_STATUS, 32'h0000_0005);
    for (int i = 0; i < 16; i++) begin
      s = (i < 3) ? svc[i] : 16'($urandom);
      m = (i < 3) ? 5'h08 : 5'($urandom) & 5'h1C;
      e = exp_err(s, m);
      x(12'(100 + i), s, m, !e && m[3] && s == 16'h0000, e);
    end
    $display("error flags done");
    n = 12'h800;
    ev(3, 1'b1);
    fd(n, 1);
    rd(tmu_pkg::REG_FLAG_SEL, 32'h0000_0800);
    ev(3, 1'b0);
    fd(n, 0);
    ev(3, 1'b1);
    ev(2, 1'b0);
    fd(n, 0);
    for (int c = 0; c < 4; c++) begin
      wr(tmu_pkg::REG_CTRL, 32'(c));
      rd(tmu_pkg::REG_CTRL, 32'(c));
      ev(3, 1'b1);
      ev(1, 1'b0);
      fd(n, c[0]);
      ev(3, 1'b1);
      ev(0, 1'b0);
      fd(n, c == 3);
    end
    $display("events done");
    close_out();
  end
endmodule : tenth_ms_countdown_timer_test
bind tmu_timer tmu_timer_properties u_props (.*);
